// ### rtl/mfpm_fault_manager.sv
// Fault manager: thermal shutdown, motor lock modes, measurement and position-detect faults
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Overtemp: FETs off, pump off, flags, pin
// - Thermal recovery automatic below hysteresis point
// - Shutdown flag held until fault clear
// - Thermal shutdown cannot be disabled
// - Regulator overtemp fully resets all flags
// - Latched lock: pin low, FET state by code
// - Latched lock leaves on clear plus clear
// - Auto lock: pin low, FET state by code
// - Retry expiry resumes, clears lock flags
// - Report only: flags, drivers keep running
// - Code 1xx1 ignores lock events entirely
// - Lock sets controller, lock, cause flags
// - Each lock detector has its own enable
// - Speed above limit gives overspeed lock
// - Back-EMF mismatch above limit gives lock
// - Low current for 500 ms: no motor
// - Measure ramp overflow sets ramp fault
// - Low measured back-EMF sets fault flag
// - Position detect: 12-bit timer, four rates
// - Four overflows give rise/decay timeout faults
// - Early new pulse gives rate fault
// - Position fault: abort, Hi-Z, retry later
module mfpm_fault_manager #(
   parameter longint NOMTR_CYCLES = mfpm_pkg::NOMTR_CYC,
   parameter longint RETRY_UNIT = mfpm_pkg::RETRY_UNIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Analog comparators and estimator inputs (asynchronous)
   input wire logic power_stage_overtemp_shutdown,
   input wire logic tempBelowHyst,
   input wire logic regulatorOvertemp,
   input wire mfpm_pkg::mfpm_lock_in_t lockRaw,
   input wire logic [15:0] speedEstimate,
   input wire logic [15:0] bemfDifference,
   input wire logic [15:0] phaseCurrentMin,
   input wire mfpm_pkg::mfpm_posdet_t posdetRaw,
   input wire mfpm_pkg::mfpm_meas_t measRaw,
   // Power stage and fault pin
   output mfpm_pkg::mfpm_fet_t fetState,
   output logic chargePumpEnable,
   output logic posdetAbort,
   output logic fault_indicator_n_o,
   output logic fault_indicator_n_oe
);
   import mfpm_pkg::*;

   // ==========================================
   // Input synchronisers
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [7:0] psync1;
   logic [7:0] psync2;
   always_ff @(posedge clk) begin
      sync1 <= {power_stage_overtemp_shutdown, tempBelowHyst, regulatorOvertemp};
      sync2 <= sync1;
      psync1 <= {posdetRaw, measRaw};
      psync2 <= psync1;
   end
   logic otHot;
   logic otCool;
   logic regHot;
   mfpm_posdet_t pd;
   mfpm_meas_t ms;
   assign otHot = sync2[2];
   assign otCool = sync2[1];
   assign regHot = sync2[0];
   assign pd = psync2[7:3];
   assign ms = psync2[2:0];

   // ==========================================
   // AHB-Lite register file
   logic [15:0] ctrl;
   logic [15:0] speedLimit;
   logic [15:0] bemfLimit;
   logic [15:0] currentLimit;
   logic [ST_W-1:0] status;
   logic clearPulse;
   logic wrPend;
   logic [7:0] wrAddr;
   logic [7:0] rdAddr;
   logic rdPend;
   logic accept;
   // Reset of registers and fault state when regulator overheats; bus capture and read data excluded
   logic rstAll;
   assign rstAll = !rst_n || regHot;
   assign accept = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Capture address phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
         wrAddr <= 8'h00;
         rdAddr <= 8'h00;
      end else begin
         wrPend <= accept && hwrite;
         rdPend <= accept && !hwrite;
         wrAddr <= haddr[7:0];
         rdAddr <= haddr[7:0];
      end
   end
   // Write data phase; the clear command is a one-cycle pulse, never stored
   always_ff @(posedge clk) begin
      if (rstAll) begin
         ctrl <= CTRL_RESET;
         speedLimit <= 16'hFFFF;
         bemfLimit <= 16'hFFFF;
         currentLimit <= 16'h0000;
         clearPulse <= 1'b0;
      end else begin
         clearPulse <= 1'b0;
         if (wrPend) begin
            if (wrAddr == CTRL_ADDR) begin
               ctrl <= hwdata[15:0];
            end else if (wrAddr == SPEEDLIM_ADDR) begin
               speedLimit <= hwdata[15:0];
            end else if (wrAddr == BEMFLIM_ADDR) begin
               bemfLimit <= hwdata[15:0];
            end else if (wrAddr == CURLIM_ADDR) begin
               currentLimit <= hwdata[15:0];
            end else if (wrAddr == CMD_ADDR) begin
               clearPulse <= hwdata[CLR_BIT];
            end
         end
      end
   end
   logic [3:0] motor_lock_response;
   logic [3:0] lock_retry_time;
   logic [1:0] startup_method;
   assign motor_lock_response = ctrl[MODE_LSB +: 4];
   assign lock_retry_time = ctrl[RETRY_LSB +: 4];
   assign startup_method = ctrl[STARTUP_LSB +: 2];

   // ==========================================
   // Lock detectors
   logic overspeed_event;
   logic bemf_mismatch_event;
   logic motor_absent_event;
   logic [31:0] lowCount;
   assign overspeed_event = ctrl[OVSPD_EN_BIT] && (speedEstimate > speedLimit);
   assign bemf_mismatch_event = ctrl[BEMF_EN_BIT] && (bemfDifference > bemfLimit);
   // No-motor timer; any gap in low current restarts the count
   always_ff @(posedge clk) begin
      if (rstAll || !ctrl[NOMTR_EN_BIT] || phaseCurrentMin >= currentLimit) begin
         lowCount <= 32'h0;
      end else if (lowCount < 32'(NOMTR_CYCLES)) begin
         lowCount <= lowCount + 32'h1;
      end
   end
   assign motor_absent_event = ctrl[NOMTR_EN_BIT] && (lowCount >= 32'(NOMTR_CYCLES));
   logic anyLock;
   logic [2:0] lockCause;
   assign lockCause = {overspeed_event, bemf_mismatch_event, motor_absent_event};
   assign anyLock = |lockCause;

   // ==========================================
   // Mode decode
   logic modeOff;
   logic modeLatch;
   logic modeAuto;
   logic modeReport;
   assign modeOff = motor_lock_response[3] && motor_lock_response[0];
   assign modeLatch = motor_lock_response[3:2] == 2'h0;
   assign modeAuto = motor_lock_response[3:2] == 2'h1;
   assign modeReport = motor_lock_response[3] && !modeOff;
   logic lockEvent;
   assign lockEvent = anyLock && !modeOff;

   // ==========================================
   // Position-detect timing: 12-bit timer stepping at the selected rate
   logic [1:0] rateIdx;
   logic [16:0] preCnt;
   logic [16:0] preMax;
   logic [TMR_W-1:0] pdTimer;
   logic tick;
   logic posdetFault;
   logic pdRunning;
   logic prevRamp;
   logic riseTmo;
   logic decayTmo;
   logic rateFault;
   // Prescale length for each of the four rates
   function automatic logic [16:0] rate_div(input logic [1:0] idx);
      logic [16:0] d;
      d = 17'(PRE_10M);
      for (int i = 0; i < 3; i++) begin
         if (i < int'(idx)) begin
            d = 17'(d * 10);
         end
      end
      return d;
   endfunction : rate_div
   assign preMax = rate_div(rateIdx);
   assign tick = preCnt >= preMax - 17'h1;
   assign pdRunning = pd.active && (startup_method == STARTUP_POSDET);
   always_ff @(posedge clk) begin
      preCnt <= (rstAll || !pdRunning || tick) ? 17'h0 : preCnt + 17'h1;
   end
   // Timer runs per phase; overflow steps to the next slower rate
   always_ff @(posedge clk) begin
      if (rstAll || !pdRunning || posdetFault || pd.rampUp != prevRamp) begin
         pdTimer <= '0;
         rateIdx <= 2'h0;
         riseTmo <= 1'b0;
         decayTmo <= 1'b0;
      end else if ((pd.rampUp && pd.riseDone) || (!pd.rampUp && pd.decayDone)) begin
         pdTimer <= '0;
         rateIdx <= 2'h0;
      end else if (tick) begin
         pdTimer <= pdTimer + 1'b1;
         if (&pdTimer) begin
            if (rateIdx == 2'(POSDET_RATES - 1)) begin
               riseTmo <= ctrl[TMO_EN_BIT] && pd.rampUp;
               decayTmo <= ctrl[TMO_EN_BIT] && !pd.rampUp;
            end else begin
               rateIdx <= rateIdx + 2'h1;
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      prevRamp <= rstAll ? 1'b0 : pd.rampUp;
   end
   assign rateFault = ctrl[RATE_EN_BIT] && pdRunning && pd.pulseCmd && !pd.decayDone;
   assign posdetFault = riseTmo || decayTmo || rateFault;

   // ==========================================
   // Retry timer shared by lock auto-recovery and position-detect retry
   logic [35:0] retryCnt;
   logic retryRun;
   logic retryDone;
   logic [35:0] retryLen;
   assign retryLen = 36'(RETRY_UNIT) * 36'({1'b0, lock_retry_time} + 5'h1);
   assign retryDone = retryRun && (retryCnt >= retryLen - 36'h1);
   always_ff @(posedge clk) begin
      if (rstAll) begin
         retryRun <= 1'b0;
         retryCnt <= '0;
      end else if ((lockEvent && modeAuto) || posdetFault) begin
         retryRun <= 1'b1;
         retryCnt <= '0;
      end else if (retryDone) begin
         retryRun <= 1'b0;
      end else if (retryRun) begin
         retryCnt <= retryCnt + 36'h1;
      end
   end
   // Position-detect abort held until retry runs out
   always_ff @(posedge clk) begin
      if (rstAll) begin
         posdetAbort <= 1'b0;
      end else if (posdetFault) begin
         posdetAbort <= 1'b1;
      end else if (retryDone) begin
         posdetAbort <= 1'b0;
      end
   end

   // ==========================================
   // Lock response state
   logic lockLatched;
   logic lockAuto;
   mfpm_fet_t lockFet;
   always_ff @(posedge clk) begin
      if (rstAll) begin
         lockLatched <= 1'b0;
         lockAuto <= 1'b0;
         lockFet <= MFPM_FET_NORMAL;
      end else if (lockEvent && (modeLatch || modeAuto)) begin
         lockLatched <= modeLatch;
         lockAuto <= modeAuto;
         lockFet <= motor_lock_response[1] ?
            (motor_lock_response[0] ? MFPM_FET_LOW : MFPM_FET_HIGH) : MFPM_FET_OFF;
      end else if (lockLatched && clearPulse && !anyLock) begin
         lockLatched <= 1'b0;
      end else if (lockAuto && retryDone) begin
         lockAuto <= 1'b0;
      end
   end

   // ==========================================
   // Thermal shutdown state; no enable exists
   logic thermalOff;
   always_ff @(posedge clk) begin
      if (rstAll) begin
         thermalOff <= 1'b0;
      end else if (otHot) begin
         thermalOff <= 1'b1;
      end else if (otCool) begin
         thermalOff <= 1'b0;
      end
   end

   // ==========================================
   // Status flags: a set in the same cycle as a clear wins
   logic [ST_W-1:0] setV;
   logic [ST_W-1:0] clrV;
   logic reportHeld;
   assign reportHeld = anyLock;
   always_comb begin
      setV = '0;
      clrV = '0;
      setV[ST_DRV] = otHot;
      setV[ST_OT] = otHot;
      setV[ST_OTS] = otHot;
      if (lockEvent) begin
         setV[ST_CTRL] = 1'b1;
         setV[ST_LOCK] = 1'b1;
         setV[ST_OVSPD] = overspeed_event;
         setV[ST_BEMF] = bemf_mismatch_event;
         setV[ST_NOMTR] = motor_absent_event;
      end
      setV[ST_MRAMP] = ms.active && ms.rampOverflow;
      setV[ST_MBEMF] = ms.active && ms.bemfLow;
      setV[ST_RISE] = riseTmo;
      setV[ST_DECAY] = decayTmo;
      setV[ST_RATE] = rateFault;
      // Driver and temperature flags clear on thermal recovery; shutdown flag waits for clear
      clrV[ST_DRV] = thermalOff && otCool;
      clrV[ST_OT] = thermalOff && otCool;
      if (clearPulse) begin
         clrV = clrV | ST_W'(13'h1F04);
         // Latched lock leaves in this same cycle, so only the live condition holds the flags
         if (!reportHeld) begin
            clrV = clrV | ST_W'(13'h00F8);
         end
      end
      if (lockAuto && retryDone) begin
         clrV = clrV | ST_W'(13'h00F8);
      end
   end
   always_ff @(posedge clk) begin
      if (rstAll) begin
         status <= '0;
      end else begin
         status <= (status & ~clrV) | setV;
      end
   end

   // ==========================================
   // Power stage and pin outputs
   always_ff @(posedge clk) begin
      if (rstAll) begin
         fetState <= MFPM_FET_NORMAL;
         chargePumpEnable <= 1'b1;
         fault_indicator_n_oe <= 1'b0;
      end else begin
         chargePumpEnable <= !thermalOff;
         if (thermalOff || posdetAbort) begin
            fetState <= MFPM_FET_OFF;
         end else if (lockLatched || lockAuto) begin
            fetState <= lockFet;
         end else begin
            fetState <= MFPM_FET_NORMAL;
         end
         fault_indicator_n_oe <= thermalOff || lockLatched || lockAuto;
      end
   end
   assign fault_indicator_n_o = 1'b0;

   // ==========================================
   // Read data phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0;
      end else if (accept && !hwrite) begin
         if (haddr[7:0] == CTRL_ADDR) begin
            hrdata <= {16'h0, ctrl};
         end else if (haddr[7:0] == STATUS_ADDR) begin
            hrdata <= {19'h0, status};
         end else if (haddr[7:0] == SPEEDLIM_ADDR) begin
            hrdata <= {16'h0, speedLimit};
         end else if (haddr[7:0] == BEMFLIM_ADDR) begin
            hrdata <= {16'h0, bemfLimit};
         end else if (haddr[7:0] == CURLIM_ADDR) begin
            hrdata <= {16'h0, currentLimit};
         end else if (haddr[7:0] == STATE_ADDR) begin
            hrdata <= {26'h0, rateIdx, posdetAbort, thermalOff, lockAuto, lockLatched};
         end else begin
            hrdata <= 32'h0;
         end
      end
   end

   // ==========================================
   // Checks
   property p_clear_pulse;
      @(posedge clk) disable iff (!rst_n) clearPulse |=> !clearPulse;
   endproperty
   a_clear_pulse: assert property (p_clear_pulse) else $error("clear not one cycle");
   // Power stage fully parked by a thermal event
   sequence s_stage_off;
      fetState == MFPM_FET_OFF && !chargePumpEnable && fault_indicator_n_oe;
   endsequence
   // Regulator reset may follow the event directly, so it disables the check
   property p_thermal;
      @(posedge clk) disable iff (rstAll) otHot |=> ##1 s_stage_off;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal shutdown missing");
   property p_off_mode;
      @(posedge clk) disable iff (!rst_n) modeOff && !lockLatched && !lockAuto |=> !lockLatched;
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("disabled mode acted");
   property p_report;
      @(posedge clk) disable iff (!rst_n) lockEvent && modeReport && !regHot
         |=> status[ST_LOCK] && !lockLatched && !lockAuto;
   endproperty
   a_report: assert property (p_report) else $error("report mode wrong");
   // Retry expiry without a fresh event ends auto recovery and drops its flags
   property p_auto_retry;
      @(posedge clk) disable iff (rstAll) lockAuto && retryDone && !lockEvent
         |=> !lockAuto && !status[ST_LOCK] && !status[ST_CTRL];
   endproperty
   a_auto_retry: assert property (p_auto_retry) else $error("auto retry did not recover");
   // Only a clear pulse or a lock event in auto mode lets a latched lock go
   property p_latch_hold;
      @(posedge clk) disable iff (rstAll) lockLatched && !clearPulse && !modeAuto |=> lockLatched;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched lock left early");
endmodule : mfpm_fault_manager

// ### rtl/mfpm_pkg.sv
// Package: register map, field layout, timing constants and types of the fault manager
package mfpm_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] LOCKCFG_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] CMD_ADDR = 8'h0C;
   localparam logic [7:0] SPEEDLIM_ADDR = 8'h10;
   localparam logic [7:0] BEMFLIM_ADDR = 8'h14;
   localparam logic [7:0] CURLIM_ADDR = 8'h18;
   localparam logic [7:0] STATE_ADDR = 8'h1C;
   // ==========================================
   // Control register fields
   localparam int MODE_LSB = 0;
   localparam int RETRY_LSB = 4;
   localparam int OVSPD_EN_BIT = 8;
   localparam int BEMF_EN_BIT = 9;
   localparam int NOMTR_EN_BIT = 10;
   localparam int TMO_EN_BIT = 11;
   localparam int RATE_EN_BIT = 12;
   localparam int STARTUP_LSB = 13;
   localparam int CLR_BIT = 0;
   localparam logic [1:0] STARTUP_POSDET = 2'h2;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ==========================================
   // Status bit positions
   localparam int ST_DRV = 0;
   localparam int ST_OT = 1;
   localparam int ST_OTS = 2;
   localparam int ST_CTRL = 3;
   localparam int ST_LOCK = 4;
   localparam int ST_OVSPD = 5;
   localparam int ST_BEMF = 6;
   localparam int ST_NOMTR = 7;
   localparam int ST_MRAMP = 8;
   localparam int ST_MBEMF = 9;
   localparam int ST_RISE = 10;
   localparam int ST_DECAY = 11;
   localparam int ST_RATE = 12;
   localparam int ST_W = 13;
   // ==========================================
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int NOMTR_MS = 500;
   localparam longint NOMTR_CYC = longint'(NOMTR_MS) * 1000 * CLK_MHZ;
   localparam int RETRY_UNIT_MS = 100;
   localparam longint RETRY_UNIT_CYC = longint'(RETRY_UNIT_MS) * 1000 * CLK_MHZ;
   localparam int TMR_W = 12;
   localparam int POSDET_RATES = 4;
   // Prescale per rate: 10 MHz, 1 MHz, 100 kHz, 10 kHz
   localparam int PRE_10M = 12;
   // ==========================================
   // Types
   typedef enum logic [1:0] {
      MFPM_FET_NORMAL,
      MFPM_FET_OFF,
      MFPM_FET_HIGH,
      MFPM_FET_LOW
   } mfpm_fet_t;
   typedef struct packed {
      logic overSpeed;
      logic bemfMismatch;
      logic lowCurrent;
   } mfpm_lock_in_t;
   typedef struct packed {
      logic active;
      logic riseDone;
      logic rampUp;
      logic pulseCmd;
      logic decayDone;
   } mfpm_posdet_t;
   typedef struct packed {
      logic active;
      logic rampOverflow;
      logic bemfLow;
   } mfpm_meas_t;
endpackage : mfpm_pkg

// ### testbench/motor_fault_protection_manager_test.sv
// Self-checking bench for the motor fault protection manager
`timescale 1ns/1ps
module motor_fault_protection_manager_test;
   import mfpm_pkg::*;
   // ==========================================
   // Stimulus and observation signals
   typedef struct packed {logic [15:0] ctrl; logic [1:0] fet; logic oe; logic [12:0] st;} mfpm_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic overTemp = 1'b0;
   logic tempBelowHyst = 1'b1;
   logic regulatorOvertemp = 1'b0;
   logic [15:0] speedEstimate = 16'h0200;
   logic [15:0] bemfDifference = 16'h0200;
   logic [15:0] phaseCurrentMin = 16'h0400;
   mfpm_posdet_t posdetRaw = '0;
   mfpm_meas_t measRaw = '0;
   mfpm_fet_t fetState;
   logic chargePumpEnable;
   logic posdetAbort;
   logic faultPinO;
   logic faultPinOe;
   logic [31:0] rd;
   int errors = 0;
   int checkCount = 0;
   int cycles = 0;
   mfpm_row_t rows [14];
   // ==========================================
   // Short counts keep the run small; expectations use the same values
   mfpm_fault_manager #(.NOMTR_CYCLES(50), .RETRY_UNIT(20)) u_mfpm_fault_manager (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .power_stage_overtemp_shutdown(overTemp),
      .tempBelowHyst(tempBelowHyst), .regulatorOvertemp(regulatorOvertemp), .lockRaw('0),
      .speedEstimate(speedEstimate), .bemfDifference(bemfDifference),
      .phaseCurrentMin(phaseCurrentMin), .posdetRaw(posdetRaw), .measRaw(measRaw),
      .fetState(fetState), .chargePumpEnable(chargePumpEnable), .posdetAbort(posdetAbort),
      .fault_indicator_n_o(faultPinO), .fault_indicator_n_oe(faultPinOe));
   // ==========================================
   // Clock and hang guard
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         $display("Error at %0t: run timed out", $time);
         test_done();
      end
   end
   // ==========================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // Single word transfer; called just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      rd = hrdata;
      chk({30'h0, hresp, hreadyout}, 32'h00000001, "bus response");
      if (n >= 50) chk(32'h00000001, 32'h00000000, "bus wait");
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic chkReg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      bus(1'b0, a, 32'h00000000);
      chk(rd & m, exp, "register");
   endtask : chkReg
   task automatic chkOut(input logic [1:0] f, input logic oe, input logic pump);
      chk({30'h0, fetState}, {30'h0, f}, "fet state");
      chk({31'h0, faultPinOe}, {31'h0, oe}, "fault pin");
      chk({31'h0, faultPinO}, 32'h00000000, "fault level");
      chk({31'h0, chargePumpEnable}, {31'h0, pump}, "charge pump");
   endtask : chkOut
   task automatic reset_dut();
      rst_n <= 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      cyc(1);
   endtask : reset_dut
   task automatic test_done();
      $display("Checks %0d errors %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // ==========================================
   // Main sequence
   initial begin
      // Response code, enables, FET state, pin, status
      rows = '{'{16'h0100, 2'h1, 1'b1, 13'h038}, '{16'h0101, 2'h1, 1'b1, 13'h038},
               '{16'h0102, 2'h2, 1'b1, 13'h038}, '{16'h0103, 2'h3, 1'b1, 13'h038},
               '{16'h01F4, 2'h1, 1'b1, 13'h038}, '{16'h01F5, 2'h1, 1'b1, 13'h038},
               '{16'h01F6, 2'h2, 1'b1, 13'h038}, '{16'h01F7, 2'h3, 1'b1, 13'h038},
               '{16'h0108, 2'h0, 1'b0, 13'h038}, '{16'h0209, 2'h0, 1'b0, 13'h000},
               '{16'h020F, 2'h0, 1'b0, 13'h000}, '{16'h0200, 2'h1, 1'b1, 13'h058},
               '{16'h0000, 2'h0, 1'b0, 13'h000}, '{16'h0400, 2'h0, 1'b0, 13'h000}};
      @(posedge clk);
      reset_dut();
      chkReg(CTRL_ADDR, 32'h00000000, 32'hFFFFFFFF);
      chkReg(SPEEDLIM_ADDR, 32'h0000FFFF, 32'hFFFFFFFF);
      chkReg(8'h20, 32'h00000000, 32'hFFFFFFFF);
      chkOut(2'h0, 1'b0, 1'b1);
      foreach (rows[i]) begin
         reset_dut();
         wr(SPEEDLIM_ADDR, 32'h00000100);
         wr(BEMFLIM_ADDR, 32'h00000100);
         wr(CTRL_ADDR, {16'h0000, rows[i].ctrl});
         cyc(6);
         chkOut(rows[i].fet, rows[i].oe, 1'b1);
         chkReg(STATUS_ADDR, {19'h0, rows[i].st}, 32'hFFFFFFFF);
      end
      // Latched lock needs both the condition gone and a clear
      reset_dut();
      wr(SPEEDLIM_ADDR, 32'h00000100);
      wr(CTRL_ADDR, 32'h00000100);
      cyc(6);
      wr(CMD_ADDR, 32'h00000001);
      cyc(3);
      chkOut(2'h1, 1'b1, 1'b1);
      wr(SPEEDLIM_ADDR, 32'h0000FFFF);
      cyc(3);
      chkOut(2'h1, 1'b1, 1'b1);
      wr(CMD_ADDR, 32'h00000001);
      cyc(3);
      chkOut(2'h0, 1'b0, 1'b1);
      chkReg(STATUS_ADDR, 32'h00000000, 32'hFFFFFFFF);
      // Auto recovery: short lock, retry of one unit
      reset_dut();
      wr(CTRL_ADDR, 32'h00000104);
      wr(SPEEDLIM_ADDR, 32'h00000100);
      wr(SPEEDLIM_ADDR, 32'h0000FFFF);
      cyc(2);
      chkOut(2'h1, 1'b1, 1'b1);
      cyc(50);
      chkOut(2'h0, 1'b0, 1'b1);
      chkReg(STATUS_ADDR, 32'h00000000, 32'hFFFFFFFF);
      // No motor: low current must persist for the full count
      reset_dut();
      wr(CURLIM_ADDR, 32'h00000100);
      wr(CTRL_ADDR, 32'h00000408);
      phaseCurrentMin <= 16'h0010;
      cyc(30);
      chkReg(STATUS_ADDR, 32'h00000000, 32'h00000080);
      cyc(40);
      chkReg(STATUS_ADDR, 32'h00000098, 32'hFFFFFFFF);
      chkOut(2'h0, 1'b0, 1'b1);
      phaseCurrentMin <= 16'h0400;
      // Thermal shutdown, recovery, latched shutdown flag
      reset_dut();
      overTemp <= 1'b1;
      tempBelowHyst <= 1'b0;
      cyc(6);
      chkOut(2'h1, 1'b1, 1'b0);
      chkReg(STATUS_ADDR, 32'h00000007, 32'hFFFFFFFF);
      overTemp <= 1'b0;
      tempBelowHyst <= 1'b1;
      cyc(6);
      chkOut(2'h0, 1'b0, 1'b1);
      chkReg(STATUS_ADDR, 32'h00000004, 32'hFFFFFFFF);
      wr(CMD_ADDR, 32'h00000001);
      // The clear pulse lands one cycle after the data phase
      cyc(1);
      chkReg(STATUS_ADDR, 32'h00000000, 32'hFFFFFFFF);
      // Regulator overtemp wipes every flag
      overTemp <= 1'b1;
      tempBelowHyst <= 1'b0;
      measRaw <= '{1'b1, 1'b1, 1'b1};
      cyc(6);
      chkReg(STATUS_ADDR, 32'h00000307, 32'hFFFFFFFF);
      regulatorOvertemp <= 1'b1;
      overTemp <= 1'b0;
      tempBelowHyst <= 1'b1;
      measRaw <= '0;
      cyc(6);
      regulatorOvertemp <= 1'b0;
      cyc(6);
      chkReg(STATUS_ADDR, 32'h00000000, 32'hFFFFFFFF);
      // Position detect: new pulse before decay ends
      reset_dut();
      wr(CTRL_ADDR, 32'h00005000);
      posdetRaw <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      cyc(3);
      posdetRaw <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      cyc(4);
      posdetRaw <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      cyc(8);
      chkReg(STATUS_ADDR, 32'h00001000, 32'h00001000);
      chk({31'h0, posdetAbort}, 32'h00000001, "abort");
      chk({30'h0, fetState}, 32'h00000001, "hi-z");
      test_done();
   end
endmodule : motor_fault_protection_manager_test
